// ---- shared/spi_core_pkg.sv ----
// Purpose: shared constants and types for the serial shift buffer core
// Assumes: 20 MHz ref_clk, byte-wide data
// Notes:   mode codes follow the low four control bits
package spi_core_pkg;
  localparam int          BYTE_W      = 8;
  localparam int          BIT_CNT_W   = 3;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          TMR_DIV     = 2;
  // control register one, low nibble
  localparam logic [3:0]  MODE_M_DIV4  = 4'h0;
  localparam logic [3:0]  MODE_M_DIV16 = 4'h1;
  localparam logic [3:0]  MODE_M_DIV64 = 4'h2;
  localparam logic [3:0]  MODE_M_TMR   = 4'h3;
  localparam logic [3:0]  MODE_S_SEL   = 4'h4;
  localparam logic [3:0]  MODE_S_FREE  = 4'h5;
  localparam logic [3:0]  MODE_M_ADDR  = 4'hA;
  // half-period counts in ref_clk cycles (bit period = 4, 16, 64 cycles)
  localparam logic [9:0]  HALF_DIV4    = 10'h002;
  localparam logic [9:0]  HALF_DIV16   = 10'h008;
  localparam logic [9:0]  HALF_DIV64   = 10'h020;
  localparam logic [9:0]  HALF_ONE     = 10'h001;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LEAD  = 3'b010,
    ST_TRAIL = 3'b100
  } xfer_state_t;
endpackage

// ---- shared/byte_stream_if.sv ----
// Purpose: valid/ready byte stream between the core and its fifo
// Assumes: one clock
// Notes:   none
`timescale 1ns/100ps
interface byte_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- core/byte_fifo.sv ----
// Purpose: small synchronous fifo for received bytes
// Assumes: single clock, asynchronous active-high reset
// Notes:   full and empty are exact; no write when full
`timescale 1ns/100ps
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // streams
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_s.ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_r != '0);
  assign out_s.data  = mem[rp_r];
  assign push = in_s.valid && in_s.ready;
  assign pop  = out_s.valid && out_s.ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp_r] <= in_s.data;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  chk_no_overflow: assert property (@(posedge ref_clk) disable iff (reset)
    cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

// ---- core/spi_shift_buffer_core.sv ----
// Purpose: spi-mode shift register core with receive holding buffer
// Assumes: all pins synchronous to ref_clk; slave clock oversampled
// Notes:   received bytes pass an 8-deep fifo before the data buffer
//
// Contract
// - eight-bit shift register, msb out first, new bit enters at lsb
// - drive outgoing bit on selected edge, sample incoming on opposite edge
// - both ends share idle clock polarity before any transfer
// - completed byte goes to receive buffer, sets buffer-full and irq flag
// - next byte may shift in while previous byte waits unread
// - data write loads buffer and shift register together, no tx buffering; in select mode with select high only the buffer loads
// - data write during shifting is dropped and sets write collision
// - collision flag stays set until software clears it
// - reading data buffer clears buffer-full
// - shift register reachable only through the data buffer
// - control low nibble and status top bits select role, phase, rate; status bit 7 (smp) is stored but has no effect
// - master drives serial clock, slave takes it as input
// - status low six bits read-only, top two writable; control read/write
// - unselected slave ignores clock and data and does not transmit
// - master starts by driving clock, stops clock when done
// - master starts shifting as soon as data buffer is written
// - master rate: clk/4, /16, /64, timer/2, or clk/(4*(addr+1))
// - slave sets irq flag when last bit latched
// - select high in select mode releases data out, even mid-byte
`timescale 1ns/100ps
module spi_shift_buffer_core
  import spi_core_pkg::*;
(
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset,
  // software access
  input  wire logic               ctrl_wr,
  input  wire logic [7:0]         ctrl_wdata,
  output logic [7:0]              port_control_one,
  input  wire logic               stat_wr,
  input  wire logic [1:0]         stat_wdata,
  output logic [7:0]              port_status_reg,
  input  wire logic               data_wr,
  input  wire logic [7:0]         data_wdata,
  input  wire logic               data_rd,
  output logic [7:0]              data_buffer_reg,
  input  wire logic [7:0]         address_rate_reg,
  input  wire logic               timer_tick,
  input  wire logic               irq_clr,
  output logic                    port_irq_flag,
  // serial pins
  input  wire logic               sck_in,
  output logic                    sck_out,
  output logic                    sck_oe,
  input  wire logic               sdi,
  output logic                    sdo,
  output logic                    sdo_oe,
  input  wire logic               ss_n
);
  import spi_core_pkg::*;

  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  logic [7:0] ctl_r;
  logic [1:0] stat_hi_r;
  logic       write_collision_flag_r;
  logic       en_r;
  logic       bf_r;
  logic       irq_r;
  logic [7:0] buf_r;
  logic [7:0] sr_r;
  logic [2:0] cnt_r;
  logic       sdo_r;
  logic       sck_r;
  logic       sck_oe_r;
  logic       sdo_oe_r;
  logic       done_p;
  logic       wr_ok;
  xfer_state_t st_r;

  function automatic logic is_master(input logic [3:0] m);
    is_master = (m == MODE_M_DIV4) || (m == MODE_M_DIV16) || (m == MODE_M_DIV64)
             || (m == MODE_M_TMR) || (m == MODE_M_ADDR);
  endfunction

  logic [3:0] mode;
  logic       ckp;
  logic       smp;
  logic       cke;
  logic       master;
  assign mode   = ctl_r[3:0];
  assign ckp    = ctl_r[4];
  assign en_r   = ctl_r[5];
  assign smp    = stat_hi_r[1];
  assign cke    = stat_hi_r[0];
  assign master = is_master(mode);

  // ----------------------------------------------------------------
  // registers: control one holds collision at bit 7
  // ----------------------------------------------------------------
  logic busy;
  assign busy  = (st_r != ST_IDLE);
  assign wr_ok = data_wr && !busy && !write_collision_flag_r && en_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctl_r     <= BYTE_RST;
      stat_hi_r <= 2'h0;
    end else begin
      if (ctrl_wr) begin
        ctl_r <= {1'b0, ctrl_wdata[6:0]};
      end
      if (stat_wr) begin
        stat_hi_r <= stat_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      write_collision_flag_r <= 1'b0;
    end else if (data_wr && (busy || write_collision_flag_r) && en_r) begin
      write_collision_flag_r <= 1'b1;
    end else if (ctrl_wr && !ctrl_wdata[7]) begin
      write_collision_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bit clock generation and slave edge detection
  // ----------------------------------------------------------------
  logic [9:0] div_r;
  logic [9:0] half;
  logic       tick;
  logic       sck_in_d;
  logic       sel;
  logic       lead_e;
  logic       trail_e;

  always_comb begin
    case (mode)
      MODE_M_DIV16: half = HALF_DIV16;
      MODE_M_DIV64: half = HALF_DIV64;
      MODE_M_ADDR:  half = {1'b0, address_rate_reg, 1'b0} + HALF_DIV4;
      default:      half = HALF_DIV4;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_r <= 10'h000;
    end else begin
      if (!busy || !master) begin
        div_r <= 10'h000;
      end else if (div_r + HALF_ONE >= half) begin
        div_r <= 10'h000;
      end else begin
        div_r <= div_r + HALF_ONE;
      end
    end
  end

  // timer option: each timer tick is one half period, so bit rate is timer output / 2
  assign tick = (mode == MODE_M_TMR) ? timer_tick
                                     : (div_r + HALF_ONE >= half);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sck_in_d <= 1'b0;
    end else begin
      sck_in_d <= sck_in;
    end
  end

  // slave edge relative to idle level; lead leaves idle, trail returns
  assign sel     = (mode != MODE_S_SEL) || !ss_n;
  assign lead_e  = sel && (sck_in != sck_in_d) && (sck_in_d == ckp);
  assign trail_e = sel && (sck_in != sck_in_d) && (sck_in_d != ckp);

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  logic step_lead;
  logic step_trail;
  logic launch;
  logic sample;
  assign step_lead  = master ? (st_r == ST_LEAD  && tick) : lead_e;
  assign step_trail = master ? (st_r == ST_TRAIL && tick) : trail_e;
  // cke set: launch on trail edge back to idle, sample on lead
  assign launch = cke ? step_trail : step_lead;
  assign sample = cke ? step_lead  : step_trail;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r   <= ST_IDLE;
      sr_r   <= BYTE_RST;
      cnt_r  <= 3'h0;
      sdo_r  <= 1'b0;
      sck_r  <= 1'b0;
      done_p <= 1'b0;
    end else begin
      done_p <= 1'b0;
      if (!en_r || (mode == MODE_S_SEL && ss_n)) begin
        st_r  <= ST_IDLE;
        cnt_r <= 3'h0;
        sck_r <= ckp;
      end else begin
        if (wr_ok) begin
          sr_r  <= data_wdata;
          sdo_r <= cke ? data_wdata[7] : sdo_r;
        end
        if (master) begin
          case (st_r)
            ST_IDLE: begin
              sck_r <= ckp;
              if (wr_ok) begin
                st_r <= ST_LEAD;
              end
            end
            ST_LEAD: begin
              if (tick) begin
                sck_r <= !ckp;
                st_r  <= ST_TRAIL;
              end
            end
            ST_TRAIL: begin
              if (tick) begin
                sck_r <= ckp;
                // late launch samples on lead, so the count has wrapped by the last trail
                st_r  <= (cnt_r == (cke ? 3'h0 : LAST_BIT)) ? ST_IDLE : ST_LEAD;
              end
            end
            default: st_r <= ST_IDLE;
          endcase
        end else if (wr_ok || lead_e) begin
          st_r <= ST_LEAD;
        end
        if (launch && !(cke && cnt_r == 3'h0 && st_r == ST_IDLE)) begin
          sdo_r <= sr_r[7];
        end
        if (sample && busy) begin
          sr_r  <= {sr_r[6:0], sdi};
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == LAST_BIT) begin
            done_p <= 1'b1;
            if (!master) begin
              st_r <= ST_IDLE;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receive path through fifo, then holding buffer
  // ----------------------------------------------------------------
  byte_stream_if #(.W(BYTE_W)) rx_in ();
  byte_stream_if #(.W(BYTE_W)) rx_out ();
  logic [7:0] rx_byte;
  always_comb begin
    rx_byte = {sr_r[6:0], sdi};
  end
  logic       cap_r;
  logic [7:0] cap_d_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cap_r   <= 1'b0;
      cap_d_r <= BYTE_RST;
    end else if (sample && busy && cnt_r == LAST_BIT) begin
      cap_r   <= 1'b1;
      cap_d_r <= rx_byte;
    end else if (rx_in.ready) begin
      cap_r   <= 1'b0;
    end
  end
  assign rx_in.valid = cap_r;
  assign rx_in.data  = cap_d_r;
  // buffer drains fifo only when software has taken the previous byte
  assign rx_out.ready = !bf_r || data_rd;

  byte_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk (ref_clk),
    .reset   (reset),
    .in_s    (rx_in),
    .out_s   (rx_out)
  );

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      buf_r <= BYTE_RST;
      bf_r  <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      if (wr_ok) begin
        buf_r <= data_wdata;
      end else if (rx_out.valid && rx_out.ready) begin
        buf_r <= rx_out.data;
      end
      if (rx_out.valid && rx_out.ready) begin
        bf_r <= 1'b1;
      end else if (data_rd) begin
        bf_r <= 1'b0;
      end
      if (rx_out.valid && rx_out.ready) begin
        irq_r <= 1'b1;
      end else if (irq_clr) begin
        irq_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sck_oe_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else begin
      sck_oe_r <= en_r && master;
      sdo_oe_r <= en_r && sel;
    end
  end

  // ----------------------------------------------------------------
  // outputs, registered
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      port_control_one <= BYTE_RST;
      port_status_reg  <= BYTE_RST;
      data_buffer_reg  <= BYTE_RST;
      port_irq_flag    <= 1'b0;
      sck_out          <= 1'b0;
      sdo              <= 1'b0;
      sck_oe           <= 1'b0;
      sdo_oe           <= 1'b0;
    end else begin
      port_control_one <= {write_collision_flag_r, ctl_r[6:0]};
      port_status_reg  <= {stat_hi_r, 5'h00, bf_r};
      data_buffer_reg  <= buf_r;
      port_irq_flag    <= irq_r;
      sck_out          <= sck_r;
      sdo              <= sdo_r;
      sck_oe           <= sck_oe_r;
      sdo_oe           <= sdo_oe_r;
    end
  end

  chk_write_collision_flag_hold: assert property (@(posedge ref_clk) disable iff (reset)
    write_collision_flag_r && !(ctrl_wr && !ctrl_wdata[7]) |=> write_collision_flag_r)
    else $error("collision flag dropped");
  chk_busy_write: assert property (@(posedge ref_clk) disable iff (reset)
    data_wr && busy && en_r |=> write_collision_flag_r)
    else $error("busy write not flagged");
  chk_read_clears: assert property (@(posedge ref_clk) disable iff (reset)
    data_rd && !rx_out.valid |=> !bf_r)
    else $error("read did not clear full");
  chk_master_start: assert property (@(posedge ref_clk) disable iff (reset)
    wr_ok && master |=> st_r == ST_LEAD)
    else $error("master did not start");
  chk_disable_abort: assert property (@(posedge ref_clk) disable iff (reset)
    !en_r |=> st_r == ST_IDLE && cnt_r == 3'h0)
    else $error("disable did not abort");
  chk_ss_release: assert property (@(posedge ref_clk) disable iff (reset)
    mode == MODE_S_SEL && ss_n |=> ##1 !sdo_oe)
    else $error("data out still driven");
  chk_fill_flags: assert property (@(posedge ref_clk) disable iff (reset)
    rx_out.valid && rx_out.ready |=> bf_r && irq_r)
    else $error("flags not set on fill");
  chk_write_loads: assert property (@(posedge ref_clk) disable iff (reset)
    wr_ok |=> sr_r == $past(data_wdata) && buf_r == $past(data_wdata))
    else $error("write did not load both");
  chk_done_capture: assert property (@(posedge ref_clk) disable iff (reset)
    done_p |-> cap_r)
    else $error("byte done without capture");
endmodule

// ---- testbench/spi_peer_model.sv ----
// Purpose: far-side spi slave answering the core in master role
// Assumes: idle-low clock; late picks launch on trailing edge, else on leading
// Notes:   released data line toggles so a stale level never looks valid
`timescale 1ns/100ps
module spi_peer_model (
  // serial side
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  output logic            miso,
  // bench side
  input  wire logic       late,
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte,
  output int              bit_cnt
);
  logic [7:0] sh_r;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    bit_cnt = 0;
    sh_r = 8'h00;
  end
  // load on select, counter restarts so a lost bit never carries over
  // late launch: the first bit must stand before the first clock edge
  always @(negedge sel_n) begin
    sh_r = tx_byte;
    bit_cnt = 0;
    if (late) begin
      miso = sh_r[7];
      sh_r = {sh_r[6:0], 1'b0};
    end
  end
  always @(posedge sel_n) miso = ~miso;
  // same idle level as the core: first leading edge is a rise
  always @(posedge sck) begin
    if (!sel_n) begin
      if (late) begin
        rx_byte = {rx_byte[6:0], mosi};
        bit_cnt++;
      end else begin
        miso = sh_r[7];
        sh_r = {sh_r[6:0], 1'b0};
      end
    end
  end
  always @(negedge sck) begin
    if (!sel_n) begin
      if (late) begin
        miso = sh_r[7];
        sh_r = {sh_r[6:0], 1'b0};
      end else begin
        rx_byte = {rx_byte[6:0], mosi};
        bit_cnt++;
      end
    end
  end
endmodule

// ---- testbench/spi_shift_buffer_core_tb.sv ----
// Purpose: self-checking bench for the serial shift buffer core
// Assumes: 20 MHz ref_clk, peer model stands in for the far side
// Notes:   timer rate mode checked for data only, its period is loosely defined
`timescale 1ns/100ps
module spi_shift_buffer_core_tb;
  import spi_core_pkg::*;
  logic       ref_clk, reset, ctrl_wr, stat_wr, data_wr, data_rd, timer_tick, irq_clr;
  logic [7:0] ctrl_wdata, data_wdata, address_rate_reg, port_control_one;
  logic [7:0] port_status_reg, data_buffer_reg, peer_tx, peer_rx;
  logic [1:0] stat_wdata;
  logic       port_irq_flag, sck_in, sck_out, sck_oe, sdo, sdo_oe, ss_n, sdi;
  logic       peer_sel_n, peer_miso, slv, tb_mosi, peer_late;
  int         err_count, check_count, cyc, peer_bits;
  time        r_prev, r_last;
  assign sdi = slv ? tb_mosi : peer_miso;
  spi_shift_buffer_core i_dut (
    .ref_clk(ref_clk), .reset(reset), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .port_control_one(port_control_one), .stat_wr(stat_wr), .stat_wdata(stat_wdata),
    .port_status_reg(port_status_reg), .data_wr(data_wr), .data_wdata(data_wdata),
    .data_rd(data_rd), .data_buffer_reg(data_buffer_reg),
    .address_rate_reg(address_rate_reg), .timer_tick(timer_tick), .irq_clr(irq_clr),
    .port_irq_flag(port_irq_flag), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .ss_n(ss_n));
  spi_peer_model i_peer (.sck(sck_out), .mosi(sdo), .sel_n(peer_sel_n), .miso(peer_miso),
    .late(peer_late), .tx_byte(peer_tx), .rx_byte(peer_rx), .bit_cnt(peer_bits));
  // ----------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    timer_tick <= (cyc % 4 == 0);
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      test_done();
    end
  end
  always @(posedge sck_out) begin
    r_prev = r_last;
    r_last = $time;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_bf(input int n);
    for (int i = 0; i < n && port_status_reg[0] !== 1'b1; i++) cyc_wait(1);
  endtask
  task automatic ctrl(input logic [7:0] v);
    @(posedge ref_clk) ctrl_wr <= 1'b1;
    ctrl_wdata <= v;
    @(posedge ref_clk) ctrl_wr <= 1'b0;
  endtask
  task automatic stat(input logic [1:0] v);
    @(posedge ref_clk) stat_wr <= 1'b1;
    stat_wdata <= v;
    @(posedge ref_clk) stat_wr <= 1'b0;
  endtask
  // disable, rewrite, enable
  task automatic cfg(input logic [3:0] mode);
    ctrl(8'h00);
    ctrl({4'h2, mode});
    cyc_wait(2);
  endtask
  task automatic wr_data(input logic [7:0] v);
    @(posedge ref_clk) data_wr <= 1'b1;
    data_wdata <= v;
    @(posedge ref_clk) data_wr <= 1'b0;
  endtask
  task automatic rd_data();
    @(posedge ref_clk) data_rd <= 1'b1;
    @(posedge ref_clk) data_rd <= 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic xfer(input logic [3:0] mode, input logic [7:0] tx, input logic [7:0] ptx,
                      input int per);
    cfg(mode);
    peer_tx <= ptx;
    peer_sel_n <= 1'b0;
    wr_data(tx);
    cyc_wait(1);
    chk(data_buffer_reg, tx);
    chk(sck_oe, 1'b1);
    wait_bf(1200);
    chk(port_status_reg[0], 1'b1);
    chk(port_irq_flag, 1'b1);
    chk(data_buffer_reg, ptx);
    chk(peer_rx, tx);
    chk(peer_bits, 8);
    if (per > 0) chk(r_last - r_prev, per * 50);
    rd_data();
    cyc_wait(2);
    chk(port_status_reg[0], 1'b0);
    @(posedge ref_clk) irq_clr <= 1'b1;
    @(posedge ref_clk) irq_clr <= 1'b0;
    peer_sel_n <= 1'b1;
    cyc_wait(2);
    chk(port_irq_flag, 1'b0);
  endtask
  task automatic collide();
    cfg(MODE_M_DIV16);
    peer_sel_n <= 1'b0;
    wr_data(8'h11);
    cyc_wait(6);
    wr_data(8'h22);
    cyc_wait(2);
    chk(port_control_one[7], 1'b1);
    wait_bf(400);
    chk(peer_rx, 8'h11);
    rd_data();
    wr_data(8'h33);
    cyc_wait(200);
    chk(port_status_reg[0], 1'b0);
    chk(port_control_one[7], 1'b1);
    ctrl(8'h20);
    cyc_wait(2);
    chk(port_control_one, 8'h20);
    peer_sel_n <= 1'b1;
  endtask
  task automatic abort_mid();
    cfg(MODE_M_DIV64);
    peer_sel_n <= 1'b0;
    wr_data(8'hF0);
    cyc_wait(100);
    ctrl(8'h00);
    cyc_wait(600);
    chk(port_status_reg[0], 1'b0);
    chk(sck_out, 1'b0);
    peer_sel_n <= 1'b1;
    xfer(MODE_M_DIV4, 8'h81, 8'h7E, 4);
  endtask
  task automatic slave(input logic [3:0] mode, input logic [7:0] b, input logic sel);
    logic rx_exp;
    // a slave without select mode ignores its select pin and takes the byte
    rx_exp = (mode != MODE_S_SEL) || !sel;
    cfg(mode);
    slv <= 1'b1;
    ss_n <= sel;
    for (int i = 7; i >= 0; i--) begin
      cyc_wait(4);
      sck_in <= 1'b1;
      tb_mosi <= b[i];
      cyc_wait(4);
      sck_in <= 1'b0;
      if (i == 3 && mode == MODE_S_SEL) chk(sdo_oe, !sel);
    end
    wait_bf(20);
    chk(port_status_reg[0], rx_exp);
    if (rx_exp) begin
      chk(port_irq_flag, 1'b1);
      chk(data_buffer_reg, b);
      rd_data();
    end
    ss_n <= 1'b1;
    cyc_wait(4);
    if (mode == MODE_S_SEL) chk(sdo_oe, 1'b0);
    chk(sck_oe, 1'b0);
    @(posedge ref_clk) irq_clr <= 1'b1;
    @(posedge ref_clk) irq_clr <= 1'b0;
    slv <= 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {ref_clk, ctrl_wr, stat_wr, data_wr, data_rd, timer_tick, irq_clr, sck_in} = '0;
    {ctrl_wdata, data_wdata, peer_tx, stat_wdata, tb_mosi, slv, peer_late} = '0;
    {err_count, check_count, cyc, r_prev, r_last} = '0;
    address_rate_reg = 8'h01;
    ss_n = 1'b1;
    peer_sel_n = 1'b1;
    reset = 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    cyc_wait(1);
    chk({port_control_one, port_status_reg, data_buffer_reg}, 24'h0);
    stat(2'h3);
    cyc_wait(2);
    chk(port_status_reg, 8'hC0);
    stat(2'h0);
    ctrl(8'h7A);
    cyc_wait(2);
    chk(port_control_one, 8'h7A);
    xfer(MODE_M_DIV4, 8'hA5, 8'h3C, 4);
    xfer(MODE_M_DIV16, 8'h01, 8'h80, 16);
    xfer(MODE_M_DIV64, 8'hFF, 8'h00, 64);
    xfer(MODE_M_ADDR, 8'h5A, 8'hC3, 8);
    xfer(MODE_M_TMR, 8'h96, 8'h69, 0);
    peer_late <= 1'b1;
    stat(2'h1);
    xfer(MODE_M_DIV16, 8'hC5, 8'h3A, 16);
    peer_late <= 1'b0;
    stat(2'h0);
    collide();
    abort_mid();
    slave(MODE_S_SEL, 8'hB4, 1'b1);
    slave(MODE_S_SEL, 8'h4B, 1'b0);
    slave(MODE_S_FREE, 8'hE1, 1'b1);
    test_done();
  end
endmodule
